// [src/analog_cmp_ctrl.sv]
// Control, edge detection and register file around two analog comparators
`timescale 1ns/1ps
`default_nettype none
`include "analog_cmp_regs.svh"

// Operation
// - result one when negative below positive; invert bit flips it
// - two independent channels, own control state
// - interrupt and trigger edges chosen separately
// - result drives pin, interrupt, ADC trigger
// - negative fixed; positive selectable among three
// - channel zero: 00,01 pin, 10 reference
// - channel one: 00 own, 01 zero, 10 reference
// - output pins are GPIO until alternate chosen
// - ladder disabled gives ground for any tap
// - low range: tap plus eight over 31
// - high range: tap over 23, no offset
// - status bit shows live comparator result
module analog_cmp_ctrl
   import analog_cmp_pkg::*;
#(
   parameter int CHANNELS = 2
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire reg_req_t reg_req,
   output logic [31:0] rd_data,
   input wire logic [CHANNELS-1:0] compare_result,
   output mux_sel_t [CHANNELS-1:0] positive_mux,
   output ladder_ctl_t ladder_ctl,
   output logic [4:0] ladder_numerator,
   output logic [4:0] ladder_denominator,
   input wire logic [CHANNELS-1:0] alternate_function_select,
   input wire logic [CHANNELS-1:0] gpio_out_data,
   output logic [CHANNELS-1:0] cmp_out_pin,
   output logic [CHANNELS-1:0] adc_trigger,
   output logic irq
);

   // ==========================================
   // Register state
   logic [31:0] ctl [CHANNELS];
   logic [31:0] next_ctl [CHANNELS];
   logic [CHANNELS-1:0] raw_irq_status;
   logic [CHANNELS-1:0] next_raw_irq_status;
   logic [CHANNELS-1:0] irq_enable_mask;
   logic [CHANNELS-1:0] next_irq_enable_mask;
   logic [9:0] reference_ladder_control;
   logic [9:0] next_reference_ladder_control;
   logic [31:0] next_rd_data;
   logic [CHANNELS-1:0] irq_event;
   logic [CHANNELS-1:0] result_value_bit;

   // ==========================================
   // Per-channel synchroniser, edge sense and pin routing
   genvar ch;
   generate
      for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
         logic sync_a;
         logic sync_b;
         logic prev;
         logic [1:0] mute_cnt;
         logic [1:0] last_src;
         logic next_sync_a;
         logic next_sync_b;
         logic next_prev;
         logic [1:0] next_mute_cnt;
         logic [1:0] next_last_src;
         logic src_moved;
         logic value;
         logic rise;
         logic fall;
         logic quiet;
         logic irq_hit;
         logic trig_hit;
         logic next_trig;
         logic trig_q;
         source_sel_t src;
         sense_t irq_sense;
         sense_t trig_sense;

         assign src = source_sel_t'(ctl[ch][`CTL_SOURCE_MSB:`CTL_SOURCE_LSB]);
         assign irq_sense = sense_t'(ctl[ch][`CTL_IRQ_SENSE_MSB:`CTL_IRQ_SENSE_LSB]);
         assign trig_sense = sense_t'(ctl[ch][`CTL_TRIG_SENSE_MSB:`CTL_TRIG_SENSE_LSB]);

         always_comb begin
            // Raw input is high when negative input is below positive
            next_sync_a = compare_result[ch];
            next_sync_b = sync_a;
            // Edge logic sees only the second stage
            value = sync_b ^ ctl[ch][`CTL_INVERT_BIT];
            next_prev = value;
            next_last_src = src;
            src_moved = (src != source_sel_t'(last_src));
            // A source change can glitch the analog output, and the glitch
            // needs both sync stages and the edge register to pass through;
            // a single muted cycle would let it out as a false edge
            if (src_moved) begin
               next_mute_cnt = 2'h3;
            end else if (mute_cnt != 2'h0) begin
               next_mute_cnt = mute_cnt - 2'h1;
            end else begin
               next_mute_cnt = 2'h0;
            end
            rise = value & ~prev;
            fall = ~value & prev;
            quiet = (mute_cnt != 2'h0) | src_moved | (src == SRC_RESERVED);
            unique case (irq_sense)
               SENSE_LEVEL: irq_hit = (value == ctl[ch][`CTL_IRQ_LEVEL_BIT]);
               SENSE_FALLING: irq_hit = fall;
               SENSE_RISING: irq_hit = rise;
               SENSE_BOTH: irq_hit = rise | fall;
            endcase
            // Trigger has its own sense field, independent of the interrupt
            unique case (trig_sense)
               SENSE_LEVEL: trig_hit = (value == ctl[ch][`CTL_TRIG_LEVEL_BIT]);
               SENSE_FALLING: trig_hit = fall;
               SENSE_RISING: trig_hit = rise;
               SENSE_BOTH: trig_hit = rise | fall;
            endcase
            next_trig = trig_hit & ctl[ch][`CTL_TRIG_ENABLE_BIT] & ~quiet;
         end

         always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
               sync_a <= 1'b0;
               sync_b <= 1'b0;
               prev <= 1'b0;
               mute_cnt <= 2'h0;
               last_src <= 2'h0;
               trig_q <= 1'b0;
            end else begin
               sync_a <= next_sync_a;
               sync_b <= next_sync_b;
               prev <= next_prev;
               mute_cnt <= next_mute_cnt;
               last_src <= next_last_src;
               trig_q <= next_trig;
            end
         end

         assign irq_event[ch] = irq_hit & ~quiet;
         assign adc_trigger[ch] = trig_q;
         assign result_value_bit[ch] = value;

         // Negative input is always the channel's own pin; only positive is muxed
         always_comb begin
            unique case (src)
               SRC_OWN_PIN: positive_mux[ch] = (ch == 0) ? MUX_ZERO_PIN : MUX_OWN_PIN;
               SRC_ZERO_PIN: positive_mux[ch] = MUX_ZERO_PIN;
               SRC_REFERENCE: positive_mux[ch] = MUX_REFERENCE;
               SRC_RESERVED: positive_mux[ch] = MUX_OPEN;
            endcase
         end

         // Pin stays GPIO until the alternate function is chosen
         always_comb begin
            if (alternate_function_select[ch]) begin
               cmp_out_pin[ch] = value;
            end else begin
               cmp_out_pin[ch] = gpio_out_data[ch];
            end
         end
      end
   endgenerate

   // ==========================================
   // Resistor ladder
   always_comb begin
      ladder_ctl.enable = reference_ladder_control[`LADDER_ENABLE_BIT];
      ladder_ctl.range = reference_ladder_control[`LADDER_RANGE_BIT];
      ladder_ctl.tap = reference_ladder_control[`LADDER_TAP_MSB:`LADDER_TAP_LSB];
      if (!ladder_ctl.enable) begin
         // Ground whatever the tap holds
         ladder_numerator = 5'h00;
         ladder_denominator = `LADDER_TOTAL_HIGH_RANGE;
      end else if (!ladder_ctl.range) begin
         ladder_numerator = {1'b0, ladder_ctl.tap} + `LADDER_OFFSET_LOW_RANGE;
         ladder_denominator = `LADDER_TOTAL_LOW_RANGE;
      end else begin
         ladder_numerator = {1'b0, ladder_ctl.tap};
         ladder_denominator = `LADDER_TOTAL_HIGH_RANGE;
      end
   end

   // ==========================================
   // Sticky interrupt status
   always_comb begin
      next_raw_irq_status = raw_irq_status;
      // Clear by writing one at the masked status offset
      if (reg_req.wr && reg_req.addr == `OFS_MASKED_IRQ_STATUS) begin
         next_raw_irq_status = raw_irq_status & ~reg_req.wdata[CHANNELS-1:0];
      end
      // Set wins over clear, so an event in the clear cycle is not lost
      next_raw_irq_status = next_raw_irq_status | irq_event;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         raw_irq_status <= '0;
      end else begin
         raw_irq_status <= next_raw_irq_status;
      end
   end

   // ==========================================
   // Interrupt mask and ladder control
   always_comb begin
      next_irq_enable_mask = irq_enable_mask;
      next_reference_ladder_control = reference_ladder_control;
      if (reg_req.wr && reg_req.addr == `OFS_IRQ_ENABLE_MASK) begin
         next_irq_enable_mask = reg_req.wdata[CHANNELS-1:0];
      end
      // Reserved ladder bits are dropped and read back as zero
      if (reg_req.wr && reg_req.addr == `OFS_REFERENCE_LADDER_CONTROL) begin
         next_reference_ladder_control = reg_req.wdata[9:0] & 10'h30F;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         irq_enable_mask <= '0;
         reference_ladder_control <= 10'h000;
      end else begin
         irq_enable_mask <= next_irq_enable_mask;
         reference_ladder_control <= next_reference_ladder_control;
      end
   end

   // ==========================================
   // Channel control words
   always_comb begin
      for (int i = 0; i < CHANNELS; i++) begin
         next_ctl[i] = ctl[i];
      end
      // Each channel has its own word; a write to one never touches the other
      if (reg_req.wr && reg_req.addr == `OFS_CMP_ZERO_CONTROL) begin
         next_ctl[0] = reg_req.wdata & `CTL_WRITE_MASK;
      end
      if (reg_req.wr && reg_req.addr == `OFS_CMP_ONE_CONTROL) begin
         next_ctl[1] = reg_req.wdata & `CTL_WRITE_MASK;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < CHANNELS; i++) begin
            ctl[i] <= `RESET_VALUE;
         end
      end else begin
         for (int i = 0; i < CHANNELS; i++) begin
            ctl[i] <= next_ctl[i];
         end
      end
   end

   // ==========================================
   // Read path
   // Read data stands one cycle only, then returns to zero
   always_comb begin
      next_rd_data = 32'h0000_0000;
      if (reg_req.rd) begin
         unique case (reg_req.addr)
            `OFS_MASKED_IRQ_STATUS: next_rd_data[CHANNELS-1:0] = raw_irq_status & irq_enable_mask;
            `OFS_RAW_IRQ_STATUS: next_rd_data[CHANNELS-1:0] = raw_irq_status;
            `OFS_IRQ_ENABLE_MASK: next_rd_data[CHANNELS-1:0] = irq_enable_mask;
            `OFS_REFERENCE_LADDER_CONTROL: next_rd_data[9:0] = reference_ladder_control;
            `OFS_CMP_ZERO_STATUS: next_rd_data[`STAT_RESULT_VALUE_BIT] = result_value_bit[0];
            `OFS_CMP_ZERO_CONTROL: next_rd_data = ctl[0];
            `OFS_CMP_ONE_STATUS: next_rd_data[`STAT_RESULT_VALUE_BIT] = result_value_bit[1];
            `OFS_CMP_ONE_CONTROL: next_rd_data = ctl[1];
            default: next_rd_data = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rd_data <= `RESET_VALUE;
      end else begin
         rd_data <= next_rd_data;
      end
   end

   // ==========================================
   // Interrupt output

   // Level interrupt while any enabled status bit is pending
   assign irq = |(raw_irq_status & irq_enable_mask);

endmodule
`default_nettype wire

// [src/analog_cmp_regs.svh]
// Register offsets, field positions and reset values of the comparator control block
`ifndef ANALOG_CMP_REGS_SVH
`define ANALOG_CMP_REGS_SVH

// ==========================================
// Register byte offsets
`define OFS_MASKED_IRQ_STATUS 12'h000
`define OFS_RAW_IRQ_STATUS 12'h004
`define OFS_IRQ_ENABLE_MASK 12'h008
`define OFS_REFERENCE_LADDER_CONTROL 12'h010
`define OFS_CMP_ZERO_STATUS 12'h020
`define OFS_CMP_ZERO_CONTROL 12'h024
`define OFS_CMP_ONE_STATUS 12'h040
`define OFS_CMP_ONE_CONTROL 12'h044

// ==========================================
// Reference ladder control fields
`define LADDER_ENABLE_BIT 9
`define LADDER_RANGE_BIT 8
`define LADDER_TAP_MSB 3
`define LADDER_TAP_LSB 0
`define LADDER_TOTAL_LOW_RANGE 5'h1F
`define LADDER_OFFSET_LOW_RANGE 5'h08
`define LADDER_TOTAL_HIGH_RANGE 5'h17

// ==========================================
// Channel control fields
`define CTL_INVERT_BIT 1
`define CTL_IRQ_SENSE_MSB 3
`define CTL_IRQ_SENSE_LSB 2
`define CTL_IRQ_LEVEL_BIT 4
`define CTL_TRIG_SENSE_MSB 6
`define CTL_TRIG_SENSE_LSB 5
`define CTL_TRIG_LEVEL_BIT 7
`define CTL_SOURCE_MSB 10
`define CTL_SOURCE_LSB 9
`define CTL_TRIG_ENABLE_BIT 11
`define CTL_WRITE_MASK 32'h0000_0FFE

// ==========================================
// Channel status fields
`define STAT_RESULT_VALUE_BIT 1

// ==========================================
// Reset values
`define RESET_VALUE 32'h0000_0000

`endif

// [src/analog_cmp_pkg.sv]
// Types shared by the comparator control block
package analog_cmp_pkg;

   // Positive input source codes
   typedef enum logic [1:0] {
      SRC_OWN_PIN = 2'h0,
      SRC_ZERO_PIN = 2'h1,
      SRC_REFERENCE = 2'h2,
      SRC_RESERVED = 2'h3
   } source_sel_t;

   // Edge sense codes for interrupt and trigger
   typedef enum logic [1:0] {
      SENSE_LEVEL = 2'h0,
      SENSE_FALLING = 2'h1,
      SENSE_RISING = 2'h2,
      SENSE_BOTH = 2'h3
   } sense_t;

   // Analog mux steering for one comparator
   typedef enum logic [1:0] {
      MUX_OWN_PIN,
      MUX_ZERO_PIN,
      MUX_REFERENCE,
      MUX_OPEN
   } mux_sel_t;

   // Resistor ladder steering
   typedef struct packed {
      logic enable;
      logic range;
      logic [3:0] tap;
   } ladder_ctl_t;

   // Software register bus request
   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

endpackage

// [test/analog_cmp_ctrl_sva.sv]
// Port checker for the comparator control block
`timescale 1ns/1ps
`default_nettype none
module analog_cmp_ctrl_sva
   import analog_cmp_pkg::*;
#(
   parameter int CHANNELS = 2
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire reg_req_t reg_req,
   input wire mux_sel_t [CHANNELS-1:0] positive_mux,
   input wire ladder_ctl_t ladder_ctl,
   input wire logic [4:0] ladder_numerator,
   input wire logic [4:0] ladder_denominator,
   input wire logic [CHANNELS-1:0] alternate_function_select,
   input wire logic [CHANNELS-1:0] gpio_out_data,
   input wire logic [CHANNELS-1:0] cmp_out_pin,
   input wire logic [CHANNELS-1:0] adc_trigger
);
   // ==========================================
   // Assertions
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   chk_ladder_off: assert property (!ladder_ctl.enable |-> ladder_numerator == 5'h00)
      else $error("ladder off but tap not ground");
   chk_ladder_low: assert property (ladder_ctl.enable && !ladder_ctl.range |->
      ladder_numerator == ladder_ctl.tap + 5'h08 && ladder_denominator == 5'h1F) else $error("low range wrong");
   chk_ladder_high: assert property (ladder_ctl.enable && ladder_ctl.range |->
      ladder_numerator == {1'b0, ladder_ctl.tap} && ladder_denominator == 5'h17) else $error("high range wrong");
   chk_gpio_zero: assert property (!alternate_function_select[0] |-> cmp_out_pin[0] == gpio_out_data[0])
      else $error("pin zero not general purpose");
   chk_gpio_one: assert property (!alternate_function_select[1] |-> cmp_out_pin[1] == gpio_out_data[1])
      else $error("pin one not general purpose");
   chk_zero_source: assert property (positive_mux[0] != MUX_OWN_PIN)
      else $error("channel zero on own pin code");
   chk_open_quiet: assert property (positive_mux[0] == MUX_OPEN || $past(positive_mux[0]) == MUX_OPEN |->
      !adc_trigger[0]) else $error("trigger with open input");
   chk_mux_zero: assert property ($changed(positive_mux[0]) |-> $past(reg_req.wr) &&
      $past(reg_req.addr) == 12'h024) else $error("channel zero source moved");
   chk_mux_one: assert property ($changed(positive_mux[1]) |-> $past(reg_req.wr) &&
      $past(reg_req.addr) == 12'h044) else $error("channel one source moved");
   cover property ($rose(adc_trigger[0]));
   cover property (positive_mux[1] == MUX_ZERO_PIN);
   cover property (ladder_ctl.enable && ladder_ctl.range);
endmodule
`default_nettype wire

// [test/analog_front_model.sv]
// Behavioural analog side: pins, ladder and both comparators
`timescale 1ns/1ps
`default_nettype none
module analog_front_model
   import analog_cmp_pkg::*;
(
   input wire logic sys_clk,
   input wire logic [1:0][11:0] neg_mv,
   input wire logic [1:0][11:0] pos_mv,
   input wire mux_sel_t [1:0] positive_mux,
   input wire logic [4:0] ladder_numerator,
   input wire logic [4:0] ladder_denominator,
   output logic [1:0] compare_result
);
   // ==========================================
   // Comparators
   logic chatter = 1'b0;
   int ref_mv;
   int vp;
   // A floating input must not look like a steady level
   always @(posedge sys_clk) chatter <= ~chatter;
   always_comb begin
      ref_mv = (ladder_denominator == 5'h00) ? 0 : 32'hCE4 * ladder_numerator / ladder_denominator;
      for (int i = 0; i < 2; i++) begin
         case (positive_mux[i])
            MUX_OWN_PIN: vp = pos_mv[i];
            MUX_ZERO_PIN: vp = pos_mv[0];
            MUX_REFERENCE: vp = ref_mv;
            default: vp = -1;
         endcase
         compare_result[i] = (vp < 0) ? chatter ^ i[0] : (neg_mv[i] < vp);
      end
   end
endmodule
`default_nettype wire

// [test/tb_top.sv]
// Self-checking bench for the comparator control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import analog_cmp_pkg::*;
   // ==========================================
   // Stimulus, model and checks
   logic sys_clk = 0;
   logic rst = 1;
   reg_req_t reg_req = '0;
   logic [1:0] alt = '0;
   logic [1:0] gpo = 2'h2;
   logic [1:0][11:0] neg_mv = {12'h9C4, 12'h9C4};
   logic [1:0][11:0] pos_mv = {12'h7D0, 12'h7D0};
   logic [31:0] rd_data;
   logic [1:0] cmp_res, cmp_out_pin, adc_trigger;
   mux_sel_t [1:0] positive_mux;
   ladder_ctl_t ladder_ctl;
   logic [4:0] num, digital_input_enable;
   logic irq;
   int bad_count = 0, tests_run = 0, cyc = 0, trig_cnt = 0;
   logic [37:0] rows [12] = '{{12'h010, 12'h20C, 14'h129F}, {12'h010, 12'h30C, 14'h1197}, {12'h010, 12'h20F, 14'h12FF},
      {12'h024, 12'h000, 14'h12FF}, {12'h024, 12'h200, 14'h12FF}, {12'h024, 12'h400, 14'h22FF},
      {12'h044, 12'h200, 14'h26FF}, {12'h044, 12'h400, 14'h2AFF}, {12'h044, 12'h600, 14'h2EFF},
      {12'h024, 12'h600, 14'h3EFF}, {12'h044, 12'h000, 14'h32FF}, {12'h010, 12'h10F, 14'h3017}};
   always #25 sys_clk = ~sys_clk;
   analog_cmp_ctrl dut (.sys_clk(sys_clk), .rst(rst), .reg_req(reg_req), .rd_data(rd_data), .compare_result(cmp_res),
      .positive_mux(positive_mux), .ladder_ctl(ladder_ctl), .ladder_numerator(num), .ladder_denominator(digital_input_enable),
      .alternate_function_select(alt), .gpio_out_data(gpo), .cmp_out_pin(cmp_out_pin), .adc_trigger(adc_trigger),
      .irq(irq));
   analog_front_model model (.sys_clk(sys_clk), .neg_mv(neg_mv), .pos_mv(pos_mv), .positive_mux(positive_mux),
      .ladder_numerator(num), .ladder_denominator(digital_input_enable), .compare_result(cmp_res));
   task automatic finish_test;
      if (bad_count == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      @(posedge sys_clk) reg_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk) reg_req.wr <= 1'b0;
      #1;
   endtask
   task automatic rc(input string n, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
      @(posedge sys_clk) reg_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk) reg_req.rd <= 1'b0;
      #1 chk(n, rd_data & m, e);
   endtask
   // Voltage change plus sync and edge latency
   task automatic volt(input int ch, input logic [11:0] v);
      @(posedge sys_clk) neg_mv[ch] <= v;
      repeat (6) @(posedge sys_clk);
      #1;
   endtask
   always @(posedge sys_clk) begin
      cyc++;
      if (adc_trigger[0] === 1'b1) trig_cnt++;
      if (cyc == 3000) begin
         bad_count++;
         finish_test();
      end
   end
   initial begin
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      foreach (rows[i]) begin
         wr(rows[i][37:26], {20'h0, rows[i][25:14]});
         chk("mux0", 32'(positive_mux[0]), 32'(rows[i][13:12]));
         chk("mux1", 32'(positive_mux[1]), 32'(rows[i][11:10]));
         chk("num", 32'(num), 32'(rows[i][9:5]));
         chk("den", 32'(digital_input_enable), 32'(rows[i][4:0]));
      end
      wr(12'h010, 32'h30C);
      wr(12'h024, 32'h40C);
      wr(12'h000, 32'h3);
      wr(12'h008, 32'h1);
      volt(0, 12'h3E8);
      rc("st0", 12'h020, 32'h2, 32'h2);
      chk("irq", 32'(irq), 32'h1);
      wr(12'h000, 32'h1);
      chk("irqclr", 32'(irq), 32'h0);
      wr(12'h008, 32'h0);
      volt(0, 12'h9C4);
      rc("raw", 12'h004, 32'h1, 32'h1);
      rc("mis", 12'h000, 32'h1, 32'h0);
      wr(12'h024, 32'hC28);
      wr(12'h000, 32'h1);
      wr(12'h008, 32'h1);
      trig_cnt = 0;
      volt(0, 12'h3E8);
      chk("irqrise", 32'(irq), 32'h1);
      chk("trigrise", 32'(trig_cnt), 32'h0);
      wr(12'h000, 32'h1);
      volt(0, 12'h9C4);
      chk("trigfall", 32'(trig_cnt), 32'h1);
      chk("irqfall", 32'(irq), 32'h0);
      @(posedge sys_clk) alt <= 2'h1;
      volt(0, 12'h3E8);
      chk("pin0", 32'(cmp_out_pin), 32'h3);
      rc("st1lo", 12'h040, 32'h2, 32'h0);
      volt(1, 12'h3E8);
      rc("st1hi", 12'h040, 32'h2, 32'h2);
      rc("unmap", 12'h100, 32'hFFFFFFFF, 32'h0);
      @(posedge sys_clk) rst <= 1'b1;
      @(posedge sys_clk) #1 chk("rstout", {irq, adc_trigger, num}, 8'h00);
      rst <= 1'b0;
      rc("rstctl", 12'h024, 32'hFFFFFFFF, 32'h0);
      finish_test();
   end
endmodule
bind analog_cmp_ctrl analog_cmp_ctrl_sva #(.CHANNELS(CHANNELS)) sva (.sys_clk(sys_clk), .rst(rst),
   .reg_req(reg_req), .positive_mux(positive_mux), .ladder_ctl(ladder_ctl), .ladder_numerator(ladder_numerator),
   .ladder_denominator(ladder_denominator), .alternate_function_select(alternate_function_select),
   .gpio_out_data(gpio_out_data), .cmp_out_pin(cmp_out_pin), .adc_trigger(adc_trigger));
`default_nettype wire
